// File: logic/gio_pkg.sv
package gio_pkg;

  // ****************************************
  // Geometry
  // ****************************************
  localparam int         NUM_PORTS     = 5;
  localparam int         PORT_W        = 8;
  localparam int         ADDR_W        = 8;
  localparam logic [2:0] PORT_A        = 3'h0;
  localparam logic [2:0] PORT_C        = 3'h1;
  localparam logic [2:0] PORT_D        = 3'h2;
  localparam logic [2:0] PORT_E        = 3'h3;
  localparam logic [2:0] PORT_F        = 3'h4;

  // ****************************************
  // Register offsets
  // ****************************************
  localparam logic [7:0] OFS_PORT_LAST = 8'h27;
  localparam logic [7:0] OFS_WAKE_EN   = 8'h28;
  localparam logic [7:0] OFS_PIN_IRQ   = 8'h2C;
  localparam logic [7:0] OFS_LCD       = 8'h30;
  localparam logic [7:0] OFS_BIT_OP    = 8'h34;
  localparam logic [7:0] OFS_STATUS    = 8'h38;
  localparam logic [7:0] OFS_MASK      = 8'h3C;
  localparam int         OFS_DIR_BIT   = 2;
  localparam int         OFS_IDX_LSB   = 3;

  // ****************************************
  // Reset values and pin layout
  // ****************************************
  localparam logic [7:0] RST_PORT      = 8'hFF;
  localparam logic [7:0] OD_MASK       = 8'h0C;
  localparam logic [7:0] DIR_MASK_C    = 8'hF3;
  localparam int         T0_PIN        = 4;
  localparam int         T1_PIN        = 6;
  localparam int         IRQ_PIN_A     = 0;
  localparam int         IRQ_PIN_B     = 5;
  localparam int         IRQ_PIN_C     = 7;
  localparam int         LCD_LINES     = 4;

  // ****************************************
  // Field positions
  // ****************************************
  localparam int         PIC_EN_LSB    = 0;
  localparam int         PIC_CAUSE_LSB = 4;
  localparam int         BOP_BIT_LSB   = 0;
  localparam int         BOP_VAL_BIT   = 3;
  localparam int         BOP_PORT_LSB  = 4;
  localparam int         BOP_DIR_BIT   = 7;
  localparam int         ST_WAKE       = 0;
  localparam int         ST_PIN_IRQ    = 1;
  localparam int         ST_W          = 2;

  // ****************************************
  // Bus responses
  // ****************************************
  localparam logic [1:0] RESP_OKAY     = 2'h0;
  localparam logic [1:0] RESP_SLVERR   = 2'h2;

endpackage

// File: logic/gio_port_block.sv
`timescale 1ns/1ps
// Summary of operation
// - Five ports, each a register pair, every pin except port C lines 2 and 3 tied to one bit of its direction register.
// - Port inputs are not latched; the pin level is sampled when the read is taken.
// - Written port data sits in an output latch until that latch is written again.
// - Direction bit 1 makes the pin a readable input, 0 a push-pull output.
// - Reading an output pin returns the latch, not the pin level.
// - Port C lines 2 and 3 are open-drain output-only, no pull-up, no direction bit.
// - An input pin gets a weak pull-up when the build option selects it.
// - Reset sets every data latch and direction bit high.
// - Single-bit set and clear read the whole port, change one bit, write all back.
// - In power-down, a falling edge on any enabled port A pin wakes the device.
// - Port C lines 4 and 6 feed the timer 0 and timer 1 external clocks.
// - Port C lines 0, 5 and 7 raise the pin interrupt, enabled by bits 0 to 2.
// - Bits 4 to 6 of the pin interrupt control record which pin caused it.
// - Port D lines 0 to 3 serve as LCD commons, set by the LCD common control.
module gio_port_block
  import gio_pkg::*;
#(
  parameter logic [39:0] PULLUP_OPT = 40'h00_0000_0000
) (
  input  wire logic              clk_in,
  input  wire logic              rst_in,
  input  wire logic [ADDR_W-1:0] s_axi_awaddr_in,
  input  wire logic              s_axi_awvalid_in,
  output logic                   s_axi_awready_out,
  input  wire logic [31:0]       s_axi_wdata_in,
  input  wire logic [3:0]        s_axi_wstrb_in,
  input  wire logic              s_axi_wvalid_in,
  output logic                   s_axi_wready_out,
  output logic [1:0]             s_axi_bresp_out,
  output logic                   s_axi_bvalid_out,
  input  wire logic              s_axi_bready_in,
  input  wire logic [ADDR_W-1:0] s_axi_araddr_in,
  input  wire logic              s_axi_arvalid_in,
  output logic                   s_axi_arready_out,
  output logic [31:0]            s_axi_rdata_out,
  output logic [1:0]             s_axi_rresp_out,
  output logic                   s_axi_rvalid_out,
  input  wire logic              s_axi_rready_in,
  input  wire logic [7:0]        port_a_pins_in,
  output logic [7:0]             port_a_pins_out,
  output logic [7:0]             port_a_pins_oe_n_out,
  output logic [7:0]             port_a_pullup_out,
  input  wire logic [7:0]        port_c_pins_in,
  output logic [7:0]             port_c_pins_out,
  output logic [7:0]             port_c_pins_oe_n_out,
  output logic [7:0]             port_c_pullup_out,
  input  wire logic [7:0]        port_d_pins_in,
  output logic [7:0]             port_d_pins_out,
  output logic [7:0]             port_d_pins_oe_n_out,
  output logic [7:0]             port_d_pullup_out,
  input  wire logic [7:0]        port_e_pins_in,
  output logic [7:0]             port_e_pins_out,
  output logic [7:0]             port_e_pins_oe_n_out,
  output logic [7:0]             port_e_pullup_out,
  input  wire logic [7:0]        port_f_pins_in,
  output logic [7:0]             port_f_pins_out,
  output logic [7:0]             port_f_pins_oe_n_out,
  output logic [7:0]             port_f_pullup_out,
  input  wire logic              halted_in,
  output logic                   wake_out,
  output logic                   pin_irq_out,
  output logic                   irq_out,
  input  wire logic              timer0_ext_sel_in,
  input  wire logic              timer1_ext_sel_in,
  output logic                   timer0_clock_input_out,
  output logic                   timer1_clock_input_out,
  output logic [LCD_LINES-1:0]   lcd_common_en_out,
  output logic [LCD_LINES-1:0]   lcd_common_bias_out
);

  // ****************************************
  // Helpers
  // ****************************************
  function automatic logic [7:0] eff_dir(input logic [2:0] idx, input logic [7:0] d);
    eff_dir = (idx == PORT_C) ? (d & DIR_MASK_C) : d;
  endfunction

  function automatic logic [7:0] port_view(input logic [7:0] d, input logic [7:0] e,
                                           input logic [7:0] p);
    port_view = (e & p) | (~e & d);
  endfunction

  function automatic logic addr_ok(input logic [ADDR_W-1:0] a);
    addr_ok = (a <= OFS_PORT_LAST) || (a[7:2] >= OFS_WAKE_EN[7:2] && a[7:2] <= OFS_MASK[7:2]);
  endfunction

  // ****************************************
  // State
  // ****************************************
  logic [7:0]            port_data_r [NUM_PORTS];
  logic [7:0]            port_data_nxt [NUM_PORTS];
  logic [7:0]            port_dir_r [NUM_PORTS];
  logic [7:0]            port_dir_nxt [NUM_PORTS];
  logic [7:0]            pin_prev_r [NUM_PORTS];
  logic [7:0]            pin_w [NUM_PORTS];
  logic [7:0]            fall_w [NUM_PORTS];
  logic [7:0]            pin_out_w [NUM_PORTS];
  logic [7:0]            oe_n_w [NUM_PORTS];
  logic [7:0]            pullup_w [NUM_PORTS];
  logic [7:0]            wake_en_r, wake_en_nxt;
  logic [2:0]            pic_en_r, pic_en_nxt;
  logic [2:0]            cause_r, cause_nxt, cause_evt;
  logic [7:0]            lcd_r, lcd_nxt;
  logic [ST_W-1:0]       status_r, status_nxt, mask_r, mask_nxt;
  logic                  wake_r, wake_evt;
  logic                  aw_valid_r, aw_valid_nxt, w_valid_r, w_valid_nxt;
  logic [ADDR_W-1:0]     aw_addr_r, aw_addr_nxt;
  logic [31:0]           w_data_r, w_data_nxt;
  logic                  w_lane_r, w_lane_nxt;
  logic                  bvalid_r, bvalid_nxt, rvalid_r, rvalid_nxt;
  logic [1:0]            bresp_r, bresp_nxt, rresp_r, rresp_nxt;
  logic [31:0]           rdata_r, rdata_nxt;
  logic                  do_write;
  logic                  ar_hs;

  assign pin_w[0] = port_a_pins_in;
  assign pin_w[1] = port_c_pins_in;
  assign pin_w[2] = port_d_pins_in;
  assign pin_w[3] = port_e_pins_in;
  assign pin_w[4] = port_f_pins_in;

  // ****************************************
  // Pin drivers
  // ****************************************
  for (genvar gi = 0; gi < NUM_PORTS; gi++) begin : g_pin
    localparam logic [2:0] IDX = 3'(gi);
    localparam logic [7:0] ODM = (IDX == PORT_C) ? OD_MASK : 8'h00;
    logic [7:0] lcd_m;
    assign lcd_m = (IDX == PORT_D) ? {4'h0, lcd_r[3:0]} : 8'h00;
    assign fall_w[gi]    = pin_prev_r[gi] & ~pin_w[gi];
    assign pin_out_w[gi] = port_data_r[gi] & ~ODM;
    assign oe_n_w[gi]    = (eff_dir(IDX, port_dir_r[gi]) & ~ODM) | (port_data_r[gi] & ODM)
                           | lcd_m;
    assign pullup_w[gi]  = eff_dir(IDX, port_dir_r[gi]) & PULLUP_OPT[8*gi +: 8];
  end

  assign port_a_pins_out      = pin_out_w[0];
  assign port_c_pins_out      = pin_out_w[1];
  assign port_d_pins_out      = pin_out_w[2];
  assign port_e_pins_out      = pin_out_w[3];
  assign port_f_pins_out      = pin_out_w[4];
  assign port_a_pins_oe_n_out = oe_n_w[0];
  assign port_c_pins_oe_n_out = oe_n_w[1];
  assign port_d_pins_oe_n_out = oe_n_w[2];
  assign port_e_pins_oe_n_out = oe_n_w[3];
  assign port_f_pins_oe_n_out = oe_n_w[4];
  assign port_a_pullup_out    = pullup_w[0];
  assign port_c_pullup_out    = pullup_w[1];
  assign port_d_pullup_out    = pullup_w[2];
  assign port_e_pullup_out    = pullup_w[3];
  assign port_f_pullup_out    = pullup_w[4];

  assign timer0_clock_input_out = timer0_ext_sel_in & port_c_pins_in[T0_PIN];
  assign timer1_clock_input_out = timer1_ext_sel_in & port_c_pins_in[T1_PIN];
  assign lcd_common_en_out      = lcd_r[3:0];
  assign lcd_common_bias_out    = lcd_r[7:4];

  // ****************************************
  // Events
  // ****************************************
  assign wake_evt  = halted_in & |(fall_w[0] & wake_en_r);
  assign cause_evt = {fall_w[1][IRQ_PIN_C], fall_w[1][IRQ_PIN_B], fall_w[1][IRQ_PIN_A]}
                     & pic_en_r;
  assign wake_out    = wake_r;
  assign pin_irq_out = |cause_r;
  assign irq_out     = |(status_r & mask_r);

  // ****************************************
  // Bus write channel
  // ****************************************
  assign s_axi_awready_out = ~aw_valid_r & ~bvalid_r;
  assign s_axi_wready_out  = ~w_valid_r & ~bvalid_r;
  assign s_axi_bvalid_out  = bvalid_r;
  assign s_axi_bresp_out   = bresp_r;
  assign do_write          = aw_valid_r & w_valid_r;

  always_comb begin
    aw_valid_nxt = aw_valid_r;
    aw_addr_nxt  = aw_addr_r;
    w_valid_nxt  = w_valid_r;
    w_data_nxt   = w_data_r;
    w_lane_nxt   = w_lane_r;
    bvalid_nxt   = bvalid_r;
    bresp_nxt    = bresp_r;
    if (s_axi_awvalid_in && s_axi_awready_out) begin
      aw_valid_nxt = 1'b1;
      aw_addr_nxt  = s_axi_awaddr_in;
    end
    if (s_axi_wvalid_in && s_axi_wready_out) begin
      w_valid_nxt = 1'b1;
      w_data_nxt  = s_axi_wdata_in;
      w_lane_nxt  = s_axi_wstrb_in[0];
    end
    if (do_write) begin
      aw_valid_nxt = 1'b0;
      w_valid_nxt  = 1'b0;
      bvalid_nxt   = 1'b1;
      bresp_nxt    = addr_ok(aw_addr_r) ? RESP_OKAY : RESP_SLVERR;
    end else if (bvalid_r && s_axi_bready_in) begin
      bvalid_nxt = 1'b0;
    end
  end

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      aw_valid_r <= 1'b0;
      aw_addr_r  <= '0;
      w_valid_r  <= 1'b0;
      w_data_r   <= 32'h0000_0000;
      w_lane_r   <= 1'b0;
      bvalid_r   <= 1'b0;
      bresp_r    <= RESP_OKAY;
    end else begin
      aw_valid_r <= aw_valid_nxt;
      aw_addr_r  <= aw_addr_nxt;
      w_valid_r  <= w_valid_nxt;
      w_data_r   <= w_data_nxt;
      w_lane_r   <= w_lane_nxt;
      bvalid_r   <= bvalid_nxt;
      bresp_r    <= bresp_nxt;
    end
  end

  // ****************************************
  // Bus read channel
  // ****************************************
  assign s_axi_arready_out = ~rvalid_r;
  assign s_axi_rvalid_out  = rvalid_r;
  assign s_axi_rdata_out   = rdata_r;
  assign s_axi_rresp_out   = rresp_r;
  assign ar_hs             = s_axi_arvalid_in & ~rvalid_r;

  always_comb begin
    logic [2:0] idx;
    logic [7:0] val;
    idx        = s_axi_araddr_in[OFS_IDX_LSB +: 3];
    val        = 8'h00;
    rvalid_nxt = rvalid_r;
    rdata_nxt  = rdata_r;
    rresp_nxt  = rresp_r;
    if (s_axi_araddr_in <= OFS_PORT_LAST) begin
      if (s_axi_araddr_in[OFS_DIR_BIT]) begin
        val = eff_dir(idx, port_dir_r[idx]);
      end else begin
        val = port_view(port_data_r[idx], eff_dir(idx, port_dir_r[idx]), pin_w[idx]);
      end
    end else if (s_axi_araddr_in[7:2] == OFS_WAKE_EN[7:2]) begin
      val = wake_en_r;
    end else if (s_axi_araddr_in[7:2] == OFS_PIN_IRQ[7:2]) begin
      val = {1'b0, cause_r, 1'b0, pic_en_r};
    end else if (s_axi_araddr_in[7:2] == OFS_LCD[7:2]) begin
      val = lcd_r;
    end else if (s_axi_araddr_in[7:2] == OFS_STATUS[7:2]) begin
      val = {6'h00, status_r};
    end else if (s_axi_araddr_in[7:2] == OFS_MASK[7:2]) begin
      val = {6'h00, mask_r};
    end
    if (ar_hs) begin
      rvalid_nxt = 1'b1;
      rdata_nxt  = {24'h00_0000, val};
      rresp_nxt  = addr_ok(s_axi_araddr_in) ? RESP_OKAY : RESP_SLVERR;
    end else if (rvalid_r && s_axi_rready_in) begin
      rvalid_nxt = 1'b0;
    end
  end

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      rvalid_r <= 1'b0;
      rdata_r  <= 32'h0000_0000;
      rresp_r  <= RESP_OKAY;
    end else begin
      rvalid_r <= rvalid_nxt;
      rdata_r  <= rdata_nxt;
      rresp_r  <= rresp_nxt;
    end
  end

  // ****************************************
  // Port and interrupt registers
  // ****************************************
  always_comb begin
    logic [2:0] idx;
    logic [7:0] tmp;
    idx           = w_data_r[BOP_PORT_LSB +: 3];
    tmp           = 8'h00;
    port_data_nxt = port_data_r;
    port_dir_nxt  = port_dir_r;
    wake_en_nxt   = wake_en_r;
    pic_en_nxt    = pic_en_r;
    cause_nxt     = cause_r;
    lcd_nxt       = lcd_r;
    status_nxt    = status_r;
    mask_nxt      = mask_r;
    if (do_write && w_lane_r) begin
      if (aw_addr_r <= OFS_PORT_LAST) begin
        if (aw_addr_r[OFS_DIR_BIT]) begin
          port_dir_nxt[aw_addr_r[OFS_IDX_LSB +: 3]] = w_data_r[7:0];
        end else begin
          port_data_nxt[aw_addr_r[OFS_IDX_LSB +: 3]] = w_data_r[7:0];
        end
      end else if (aw_addr_r[7:2] == OFS_WAKE_EN[7:2]) begin
        wake_en_nxt = w_data_r[7:0];
      end else if (aw_addr_r[7:2] == OFS_PIN_IRQ[7:2]) begin
        pic_en_nxt = w_data_r[PIC_EN_LSB +: 3];
        cause_nxt  = cause_r & ~w_data_r[PIC_CAUSE_LSB +: 3];
      end else if (aw_addr_r[7:2] == OFS_LCD[7:2]) begin
        lcd_nxt = w_data_r[7:0];
      end else if (aw_addr_r[7:2] == OFS_BIT_OP[7:2]) begin
        if (idx < 3'(NUM_PORTS)) begin
          if (w_data_r[BOP_DIR_BIT]) begin
            tmp = port_dir_r[idx];
            tmp[w_data_r[BOP_BIT_LSB +: 3]] = w_data_r[BOP_VAL_BIT];
            port_dir_nxt[idx] = tmp;
          end else begin
            tmp = port_view(port_data_r[idx], eff_dir(idx, port_dir_r[idx]), pin_w[idx]);
            tmp[w_data_r[BOP_BIT_LSB +: 3]] = w_data_r[BOP_VAL_BIT];
            port_data_nxt[idx] = tmp;
          end
        end
      end else if (aw_addr_r[7:2] == OFS_STATUS[7:2]) begin
        status_nxt = status_r & ~w_data_r[ST_W-1:0];
      end else if (aw_addr_r[7:2] == OFS_MASK[7:2]) begin
        mask_nxt = w_data_r[ST_W-1:0];
      end
    end
    cause_nxt               = cause_nxt | cause_evt;
    status_nxt[ST_WAKE]    = status_nxt[ST_WAKE] | wake_evt;
    status_nxt[ST_PIN_IRQ] = status_nxt[ST_PIN_IRQ] | (|cause_evt);
  end

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      for (int i = 0; i < NUM_PORTS; i++) begin
        port_data_r[i] <= RST_PORT;
        port_dir_r[i]  <= RST_PORT;
        pin_prev_r[i]  <= RST_PORT;
      end
      wake_en_r <= 8'h00;
      pic_en_r  <= 3'h0;
      cause_r   <= 3'h0;
      lcd_r     <= 8'h00;
      status_r  <= '0;
      mask_r    <= '0;
      wake_r    <= 1'b0;
    end else begin
      for (int i = 0; i < NUM_PORTS; i++) begin
        port_data_r[i] <= port_data_nxt[i];
        port_dir_r[i]  <= port_dir_nxt[i];
        pin_prev_r[i]  <= pin_w[i];
      end
      wake_en_r <= wake_en_nxt;
      pic_en_r  <= pic_en_nxt;
      cause_r   <= cause_nxt;
      lcd_r     <= lcd_nxt;
      status_r  <= status_nxt;
      mask_r    <= mask_nxt;
      wake_r    <= wake_evt;
    end
  end

  // ****************************************
  // Checks
  // ****************************************
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (rst_in);

  sequence s_wake_edge;
    halted_in && (|(fall_w[0] & wake_en_r));
  endsequence
  sequence s_wake_seen;
    wake_out && status_r[ST_WAKE] ##1 !wake_out;
  endsequence

  a_reset_all_high: assert property ($fell(rst_in) |-> port_data_r[3] == RST_PORT
    && port_dir_r[0] == RST_PORT) else $error("ports not high after reset");
  a_latch_holds: assert property (!do_write |=> port_data_r[1] == $past(port_data_r[1]))
    else $error("latch changed without a write");
  a_input_sampled: assert property (ar_hs && s_axi_araddr_in == 8'h00
    && port_dir_r[0] == 8'hFF |=> s_axi_rdata_out[7:0] == $past(port_a_pins_in))
    else $error("input read not the sampled pin");
  a_output_reads_latch: assert property (ar_hs && s_axi_araddr_in == 8'h18
    && port_dir_r[3] == 8'h00 |=> s_axi_rdata_out[7:0] == $past(port_data_r[3]))
    else $error("output read not the latch");
  a_push_pull_drive: assert property (port_e_pins_oe_n_out == port_dir_r[3]
    && port_e_pins_out == port_data_r[3]) else $error("port drive mismatch");
  a_open_drain_lines: assert property (port_c_pins_out[3:2] == 2'h0
    && port_c_pins_oe_n_out[3:2] == port_data_r[1][3:2] && port_c_pullup_out[3:2] == 2'h0)
    else $error("open-drain line misbehaves");
  a_pullup_inputs: assert property (port_a_pullup_out == (port_dir_r[0]
    & PULLUP_OPT[7:0])) else $error("pull-up mismatch");
  a_wake_pulse: assert property (s_wake_edge |=> s_wake_seen)
    else $error("wake pulse missing");
  a_cause_set: assert property (pic_en_r[0] && pin_prev_r[1][IRQ_PIN_A]
    && !port_c_pins_in[IRQ_PIN_A] |=> cause_r[0] && pin_irq_out) else $error("cause not set");
  a_cause_sticky: assert property (cause_r[2] && !(do_write
    && aw_addr_r[7:2] == OFS_PIN_IRQ[7:2]) |=> cause_r[2]) else $error("cause bit lost");
  a_timer_clock: assert property (timer1_ext_sel_in |-> timer1_clock_input_out
    == port_c_pins_in[T1_PIN]) else $error("timer clock not the pin");
  a_lcd_release: assert property (lcd_r[1] |-> port_d_pins_oe_n_out[1])
    else $error("lcd common line still driven");
  a_write_answer: assert property (s_axi_awvalid_in && s_axi_awready_out && s_axi_wvalid_in
    && s_axi_wready_out |-> ##2 s_axi_bvalid_out) else $error("write response late");

endmodule

// File: sim/gio_pins_model.sv
`timescale 1ns/1ps
// ****************************************
// Switches and circuitry on the pins
// ****************************************
module gio_pins_model (
  input  wire logic [7:0] drv_in,
  input  wire logic [7:0] oe_n_in,
  input  wire logic [7:0] ext_in,
  output logic [7:0]      level_out
);
  // Pin follows the block where it drives, else the outside switches
  assign level_out = (~oe_n_in & drv_in) | (oe_n_in & ext_in);
endmodule

// File: sim/gio_port_block_bench.sv
`timescale 1ns/1ps
`define CHK(n, e, g) begin checks_done++; if ((g) !== (e)) begin mismatches++; \
  $display("unexpected %s exp %h got %h", n, e, g); end end
module gio_port_block_bench;
  import gio_pkg::*;
  localparam logic [39:0] PU = 40'hA5_5A_3C_C3_0F;
  logic        clk_in = 0, rst_in = 1, halted = 0, sel0 = 0, sel1 = 0;
  logic [7:0]  awaddr = 0, araddr = 0, b;
  logic [31:0] wdata = 0, seed = 32'hD94C;
  logic        awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
  wire         awready, wready, bvalid, arready, rvalid, pin_irq, irq, wake, t0, t1;
  wire [1:0]   bresp, rresp;
  wire [31:0]  rdata;
  wire [3:0]   lcd_en, lcd_bias;
  logic [7:0]  ext [5] = '{default: 8'hFF};
  logic [7:0]  lat [5] = '{default: 8'hFF};
  logic [7:0]  dir [5] = '{default: 8'hFF};
  wire [7:0]   pi [5], po [5], oe [5], pu [5];
  logic [33:0] q [$];
  logic [33:0] e;
  int          mismatches = 0, checks_done = 0, c;

  gio_port_block #(.PULLUP_OPT(PU)) dut (.clk_in(clk_in), .rst_in(rst_in),
    .s_axi_awaddr_in(awaddr), .s_axi_awvalid_in(awvalid), .s_axi_awready_out(awready),
    .s_axi_wdata_in(wdata), .s_axi_wstrb_in(4'hF), .s_axi_wvalid_in(wvalid),
    .s_axi_wready_out(wready), .s_axi_bresp_out(bresp), .s_axi_bvalid_out(bvalid),
    .s_axi_bready_in(bready), .s_axi_araddr_in(araddr), .s_axi_arvalid_in(arvalid),
    .s_axi_arready_out(arready), .s_axi_rdata_out(rdata), .s_axi_rresp_out(rresp),
    .s_axi_rvalid_out(rvalid), .s_axi_rready_in(rready),
    .port_a_pins_in(pi[0]), .port_a_pins_out(po[0]), .port_a_pins_oe_n_out(oe[0]),
    .port_a_pullup_out(pu[0]), .port_c_pins_in(pi[1]), .port_c_pins_out(po[1]),
    .port_c_pins_oe_n_out(oe[1]), .port_c_pullup_out(pu[1]), .port_d_pins_in(pi[2]),
    .port_d_pins_out(po[2]), .port_d_pins_oe_n_out(oe[2]), .port_d_pullup_out(pu[2]),
    .port_e_pins_in(pi[3]), .port_e_pins_out(po[3]), .port_e_pins_oe_n_out(oe[3]),
    .port_e_pullup_out(pu[3]), .port_f_pins_in(pi[4]), .port_f_pins_out(po[4]),
    .port_f_pins_oe_n_out(oe[4]), .port_f_pullup_out(pu[4]), .halted_in(halted),
    .wake_out(wake), .pin_irq_out(pin_irq), .irq_out(irq), .timer0_ext_sel_in(sel0),
    .timer1_ext_sel_in(sel1), .timer0_clock_input_out(t0), .timer1_clock_input_out(t1),
    .lcd_common_en_out(lcd_en), .lcd_common_bias_out(lcd_bias));

  for (genvar k = 0; k < 5; k++) begin : g_pin
    gio_pins_model pm (.drv_in(po[k]), .oe_n_in(oe[k]), .ext_in(ext[k]), .level_out(pi[k]));
  end

  initial begin
    forever #2.5 clk_in = ~clk_in;
  end

  // ****************************************
  // Helpers
  // ****************************************
  function automatic logic [7:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed[7:0];
  endfunction
  function automatic logic [7:0] dm(int k);
    return k == 1 ? dir[k] & DIR_MASK_C : dir[k];
  endfunction
  function automatic logic [7:0] xr(int k);
    return (dm(k) & ext[k]) | (~dm(k) & lat[k]);
  endfunction
  task automatic conclude();
    $display("checks %0d mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  task automatic wr(input logic [7:0] a, d, input logic [1:0] r = RESP_OKAY);
    int n = 0;
    q.push_back({r, 32'h0});
    {awaddr, wdata, awvalid, wvalid, bready} <= {a, 24'h0, d, 3'b111};
    do begin
      @(posedge clk_in);
      if (awvalid && awready) awvalid <= 0;
      if (wvalid && wready) wvalid <= 0;
      if (bready && bvalid) bready <= 0;
      n++;
    end while (n < 40 && (awvalid || wvalid || bready));
    if (n == 40) begin mismatches++; conclude(); end
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r = RESP_OKAY);
    int n = 0;
    q.push_back({r, d});
    {araddr, arvalid, rready} <= {a, 2'b11};
    do begin
      @(posedge clk_in);
      if (arvalid && arready) arvalid <= 0;
      if (rready && rvalid) rready <= 0;
      n++;
    end while (n < 40 && (arvalid || rready));
    if (n == 40) begin mismatches++; conclude(); end
  endtask
  task automatic pulse(int k, logic [7:0] v, int n);
    ext[k] <= v;
    c = 0;
    repeat (4) @(posedge clk_in) c += (wake === 1'b1);
    `CHK("wake pulses", n, c)
  endtask

  always @(posedge clk_in) begin
    if ((rvalid && rready) || (bvalid && bready)) begin
      e = q.pop_front();
      `CHK("response", e, rvalid ? {rresp, rdata} : {bresp, 32'h0})
    end
  end

  // ****************************************
  // Scenarios
  // ****************************************
  initial begin
    repeat (10) @(posedge clk_in);
    rst_in <= 0;
    @(posedge clk_in);
    for (int k = 0; k < 5; k++) begin
      rd(8'(k * 8), xr(k));
      rd(8'(k * 8 + 4), dm(k));
      lat[k] = rnd();
      wr(8'(k * 8), lat[k]);
      dir[k] = rnd();
      wr(8'(k * 8 + 4), dir[k]);
      ext[k] <= rnd();
      @(posedge clk_in);
      rd(8'(k * 8), xr(k));
      `CHK("pins", k == 1 ? lat[k] & ~OD_MASK : lat[k], po[k])
      `CHK("oe", k == 1 ? (dir[k] & ~OD_MASK) | (lat[k] & OD_MASK) : dir[k], oe[k])
      `CHK("pullup", (k == 1 ? dir[k] & ~OD_MASK : dir[k]) & PU[8 * k +: 8], pu[k])
    end
    $display("ports done");
    for (int k = 0; k < 5; k++) begin
      b = rnd();
      lat[k] = xr(k);
      lat[k][b[2:0]] = b[3];
      wr(OFS_BIT_OP, {1'b0, 3'(k), b[3:0]});
      rd(8'(k * 8), xr(k));
    end
    dir[3] = 8'h00;
    wr(8'h1C, dir[3]);
    rd(8'h18, xr(3));
    $display("bit operations done");
    wr(8'h04, 8'hFF);
    wr(8'h0C, 8'hFF);
    ext[0] <= 8'hFF;
    ext[1] <= 8'hFF;
    wr(OFS_WAKE_EN, 8'h01);
    wr(OFS_MASK, 8'h01);
    halted <= 1;
    pulse(0, 8'hFD, 0);
    pulse(0, 8'hFC, 1);
    `CHK("irq", 1'b1, irq)
    rd(OFS_STATUS, 32'h1);
    wr(OFS_MASK, 8'h00);
    `CHK("irq masked", 1'b0, irq)
    wr(OFS_STATUS, 8'h01);
    rd(OFS_STATUS, 32'h0);
    $display("wake done");
    halted <= 0;
    wr(OFS_PIN_IRQ, 8'h01);
    pulse(1, 8'hDF, 0);
    rd(OFS_PIN_IRQ, 32'h01);
    pulse(1, 8'hDE, 0);
    rd(OFS_PIN_IRQ, 32'h11);
    `CHK("pin irq", 1'b1, pin_irq)
    rd(OFS_STATUS, 32'h2);
    wr(OFS_PIN_IRQ, 8'h15);
    rd(OFS_PIN_IRQ, 32'h05);
    `CHK("pin irq", 1'b0, pin_irq)
    $display("pin interrupt done");
    sel0 <= 1;
    ext[1] <= 8'h50;
    repeat (2) @(posedge clk_in);
    `CHK("timer0 clock", 1'b1, t0)
    `CHK("timer1 clock", 1'b0, t1)
    sel1 <= 1;
    @(posedge clk_in);
    @(posedge clk_in);
    `CHK("timer1 clock", 1'b1, t1)
    rd(OFS_PIN_IRQ, 32'h45);
    `CHK("pin irq", 1'b1, pin_irq)
    wr(OFS_LCD, 8'hA7);
    `CHK("lcd", 8'hA7, {lcd_bias, lcd_en})
    `CHK("lcd oe", dir[2][3:0] | 4'h7, oe[2][3:0])
    rd(OFS_PIN_IRQ, 32'h45);
    wr(8'h40, 8'h00, RESP_SLVERR);
    rd(8'h40, 32'h0, RESP_SLVERR);
    $display("shared pins done");
    repeat (2) @(posedge clk_in);
    conclude();
  end
endmodule
